// ### rtl/scs_dev.sv
/*
  Device end: serial configuration slave of the link switch, holding
  written values apart from the applied state with per-register delays.
  Assumes the host end drives the clock line and keeps it slow against
  i_sys_clk; i_addr_sel is a board strap.
*/
// Notes on behaviour
// - External-only termination: host selects lower current
// - Host keeps outputs off without any termination
// - Two-bit field picks one of four boosts
// - Fast select routes group A or B
// - Side group select independent of fast select
// - Reset restores every register default
// - Reset selects A and opens full window on fast register only
// - Address 100100 plus strap bit, MSB first
// - Write: address, register, data, each acknowledged
// - After write: stop or repeated start
// - Read: set pointer, repeated start, address read
// - Device shifts out pointed register MSB first
// - After read byte: stop or repeated start
// - Window starts at last data bit fall
// - Writes inside window apply at its end
// - Write after window applies now, reopens it
// - Fast enable zero means standby, one on
// - Fast select zero A, one B
// - Side select zero A, one B
// - Pulse bits drop input termination on switch
`timescale 1ns/1ps
`include "scs_regs.svh"
module scs_dev #(
  parameter logic [5:0][15:0] UPD_CYC = {6{`SCS_UPD_CYC}},
  parameter int unsigned PULSE_CYC = `SCS_PULSE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  scs_link_if.dev link,
  input wire logic i_addr_sel,
  output logic o_fast_switch_enable,
  output logic o_fast_source_select,
  output logic o_side_switch_enable,
  output logic o_side_source_select,
  output logic [7:0] o_in_termination_on,
  output logic [7:0] o_in_eq_high,
  output logic [1:0] o_out_boost_level,
  output logic o_out_termination_on,
  output logic o_out_current_level_sel
);
  localparam logic [5:0][7:0] DEF = {`SCS_DEF_TX, `SCS_DEF_EQ, `SCS_DEF_PT,
                                     `SCS_DEF_RX, `SCS_DEF_AUX, `SCS_DEF_HS};
  localparam logic [2:0] NONE = 3'h7;

  scs_pkg::scs_dev_t q;
  scs_pkg::scs_dev_t d;
  logic scl;
  logic scl_rise;
  logic scl_fall;
  logic sda;
  logic sda_rise;
  logic sda_fall;
  logic addr_sel;
  logic [2:0] widx;
  logic [2:0] ridx;
  logic [7:0] rd_byte;
  logic byte_done;

  // Index 0..5 of the applied state, NONE for unmapped offsets
  function automatic logic [2:0] reg_idx(input logic [7:0] a);
    case (a)
      `SCS_REG_HS: reg_idx = 3'h0;
      `SCS_REG_AUX: reg_idx = 3'h1;
      `SCS_REG_RX: reg_idx = 3'h2;
      `SCS_REG_PT: reg_idx = 3'h3;
      `SCS_REG_EQ: reg_idx = 3'h4;
      `SCS_REG_TX: reg_idx = 3'h5;
      default: reg_idx = NONE;
    endcase
  endfunction : reg_idx

  // ---------------------------------------------------------------
  // Line synchronisers
  // ---------------------------------------------------------------
  scs_sync u_scl (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_async(link.scl),
                  .o_level(scl), .o_rise(scl_rise), .o_fall(scl_fall));
  scs_sync u_sda (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_async(link.sda),
                  .o_level(sda), .o_rise(sda_rise), .o_fall(sda_fall));
  scs_sync u_adr (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_async(i_addr_sel),
                  .o_level(addr_sel), .o_rise(), .o_fall());

  // ---------------------------------------------------------------
  // Protocol and update windows
  // ---------------------------------------------------------------
  always_comb begin
    d = q;
    widx = NONE;
    ridx = reg_idx(q.ptr);
    rd_byte = (ridx == NONE) ? 8'h00 : q.wr[ridx];
    byte_done = scl_fall && (q.bits == 4'h8);
    if (q.pulse != 24'h0) begin
      d.pulse = q.pulse - 24'h1;
    end
    // Receive states sample data while the clock is high
    if (scl_rise && (q.st == scs_pkg::SD_ADDR || q.st == scs_pkg::SD_REG ||
                     q.st == scs_pkg::SD_WDAT)) begin
      d.sh = {q.sh[6:0], sda};
      d.bits = q.bits + 4'h1;
    end
    case (q.st)
      scs_pkg::SD_IDLE: begin
        d.sda_oe = 1'b0;
      end
      scs_pkg::SD_ADDR: begin
        if (byte_done) begin
          d.bits = 4'h0;
          if (q.sh[7:1] == {`SCS_DEV_ADDR_HI, addr_sel}) begin
            d.rd = q.sh[0];
            d.sda_oe = 1'b1;
            d.st = scs_pkg::SD_AACK;
          end else begin
            d.st = scs_pkg::SD_IDLE;
          end
        end
      end
      scs_pkg::SD_REG: begin
        if (byte_done) begin
          d.ptr = q.sh;
          d.sda_oe = 1'b1;
          d.st = scs_pkg::SD_RACK;
        end
      end
      scs_pkg::SD_WDAT: begin
        if (byte_done) begin
          widx = reg_idx(q.ptr);
          d.sda_oe = 1'b1;
          d.st = scs_pkg::SD_WACK;
        end
      end
      scs_pkg::SD_AACK: begin
        if (scl_fall) begin
          d.bits = 4'h0;
          if (q.rd) begin
            d.sh = rd_byte;
            d.sda_oe = ~rd_byte[7];
            d.st = scs_pkg::SD_RDAT;
          end else begin
            d.sda_oe = 1'b0;
            d.st = scs_pkg::SD_REG;
          end
        end
      end
      scs_pkg::SD_RACK: begin
        if (scl_fall) begin
          d.bits = 4'h0;
          d.sda_oe = 1'b0;
          d.st = scs_pkg::SD_WDAT;
        end
      end
      scs_pkg::SD_WACK: begin
        // One data byte per frame; further bytes go unanswered
        if (scl_fall) begin
          d.sda_oe = 1'b0;
          d.st = scs_pkg::SD_IDLE;
        end
      end
      scs_pkg::SD_RDAT: begin
        if (scl_rise) begin
          d.bits = q.bits + 4'h1;
        end else if (scl_fall) begin
          if (q.bits == 4'h8) begin
            d.sda_oe = 1'b0;
            d.st = scs_pkg::SD_MACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.sda_oe = ~q.sh[6];
          end
        end
      end
      scs_pkg::SD_MACK: begin
        if (scl_fall) begin
          d.st = scs_pkg::SD_IDLE;
        end
      end
      default: begin
        d.sda_oe = 1'b0;
        d.st = scs_pkg::SD_IDLE;
      end
    endcase
    // Start and stop override any phase; repeated start reuses the pointer
    if (scl && sda_fall) begin
      d.st = scs_pkg::SD_ADDR;
      d.bits = 4'h0;
      d.sda_oe = 1'b0;
    end else if (scl && sda_rise) begin
      d.st = scs_pkg::SD_IDLE;
      d.sda_oe = 1'b0;
    end
    if (widx != NONE) begin
      d.wr[widx] = q.sh;
    end
    for (int i = 0; i < 6; i++) begin
      if (q.cnt[i] != 16'h0) begin
        d.cnt[i] = q.cnt[i] - 16'h1;
        if (q.cnt[i] == 16'h1) begin
          d.ap[i] = d.wr[i];
        end
      end else if (widx == i[2:0]) begin
        d.ap[i] = d.wr[i];
        d.cnt[i] = UPD_CYC[i];
      end
    end
    // Termination drop follows the applied source, not the written one
    if (d.ap[0][`SCS_B_SEL] != q.ap[0][`SCS_B_SEL]) begin
      d.pulse = PULSE_CYC[23:0];
    end
    d.term = q.ap[2][`SCS_B_RXTO] ?
             ~((q.pulse != 24'h0) ? q.ap[3] : 8'h00) : 8'h00;
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '{st: scs_pkg::SD_IDLE, bits: 4'h0, sh: 8'h00, ptr: 8'h00,
             rd: 1'b0, sda_oe: 1'b0, wr: DEF, ap: DEF,
             cnt: {{5{16'h0}}, UPD_CYC[0]},
             pulse: 24'h0, term: 8'hff};
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = q.sda_oe;
  assign o_fast_switch_enable = q.ap[0][`SCS_B_EN];
  assign o_fast_source_select = q.ap[0][`SCS_B_SEL];
  assign o_side_switch_enable = q.ap[1][`SCS_B_EN];
  assign o_side_source_select = q.ap[1][`SCS_B_SEL];
  assign o_in_termination_on = q.term;
  assign o_in_eq_high = q.ap[4];
  assign o_out_boost_level = q.ap[5][`SCS_B_PE +: 2];
  assign o_out_termination_on = q.ap[5][`SCS_B_PTO];
  assign o_out_current_level_sel = q.ap[5][`SCS_B_OCL];
endmodule : scs_dev

// ### rtl/scs_regs.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  switch configuration serial link and of the host command port.
  Assumes inclusion by bare name; definitions only.
*/
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH
// ---------------------------------------------------------------
// Serial slave
// ---------------------------------------------------------------
`define SCS_DEV_ADDR_HI 6'h24
`define SCS_REG_HS 8'h00
`define SCS_REG_AUX 8'h01
`define SCS_REG_RX 8'h10
`define SCS_REG_PT 8'h11
`define SCS_REG_EQ 8'h13
`define SCS_REG_TX 8'h20
`define SCS_DEF_HS 8'h40
`define SCS_DEF_AUX 8'h40
`define SCS_DEF_RX 8'h01
`define SCS_DEF_PT 8'h00
`define SCS_DEF_EQ 8'h00
`define SCS_DEF_TX 8'h03
`define SCS_B_EN 6
`define SCS_B_SEL 0
`define SCS_B_RXTO 0
`define SCS_B_OCL 0
`define SCS_B_PTO 1
`define SCS_B_PE 2
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SCS_CLK_HZ 25000000
`define SCS_T_PULSE_MS 100
`define SCS_PULSE_CYC ((`SCS_CLK_HZ / 1000) * `SCS_T_PULSE_MS)
`define SCS_UPD_CYC 16'h0040
`define SCS_QTR_CYC 8'h3f
// ---------------------------------------------------------------
// Host APB registers
// ---------------------------------------------------------------
`define SCS_A_CMD 8'h00
`define SCS_A_STAT 8'h04
`define SCS_C_GO 0
`define SCS_C_RD 1
`define SCS_C_ASEL 2
`endif

// ### rtl/scs_pkg.sv
/*
  Types of the switch configuration serial link: state enums and the
  packed state records of both ends and of the synchroniser.
  Assumes nothing beyond SystemVerilog packages.
*/
package scs_pkg;
  typedef enum logic [8:0] {
    SD_IDLE = 9'h001, SD_ADDR = 9'h002, SD_AACK = 9'h004,
    SD_REG = 9'h008, SD_RACK = 9'h010, SD_WDAT = 9'h020,
    SD_WACK = 9'h040, SD_RDAT = 9'h080, SD_MACK = 9'h100
  } scs_dst_t;

  typedef enum logic [3:0] {
    SH_IDLE = 4'h1, SH_STA = 4'h2, SH_BIT = 4'h4, SH_STO = 4'h8
  } scs_hst_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } scs_sync_t;

  typedef struct packed {
    scs_dst_t st;
    logic [3:0] bits;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rd;
    logic sda_oe;
    logic [5:0][7:0] wr;
    logic [5:0][7:0] ap;
    logic [5:0][15:0] cnt;
    logic [23:0] pulse;
    logic [7:0] term;
  } scs_dev_t;

  typedef struct packed {
    scs_hst_t st;
    logic [7:0] div;
    logic [1:0] ph;
    logic [3:0] bits;
    logic [1:0] fr;
    logic [7:0] sh;
    logic scl_oe;
    logic sda_oe;
    logic rd;
    logic asel;
    logic [7:0] rad;
    logic [7:0] wdat;
    logic [7:0] rdat;
    logic nack;
    logic refused;
    logic pto;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } scs_host_t;
endpackage : scs_pkg

// ### rtl/scs_link_if.sv
/*
  Two-wire serial link between host end and device end.
  Both lines are open drain with a pull-up: a line is low while any
  enabled driver drives low.
*/
`timescale 1ns/1ps
interface scs_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire scl;
  wire sda;

  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input sda, output host_scl_o, output host_scl_oe,
                output host_sda_o, output host_sda_oe);
endinterface : scs_link_if

// ### rtl/scs_sync.sv
/*
  Two-flop synchroniser with edge detection on the synchronised level.
  Assumes i_async may change at any time relative to i_sys_clk.
*/
`timescale 1ns/1ps
module scs_sync (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_async,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  scs_pkg::scs_sync_t q;
  scs_pkg::scs_sync_t d;

  always_comb begin
    d = q;
    d.s1 = i_async;
    d.s2 = q.s1;
    d.s3 = q.s2;
  end

  // Idle lines are pulled high, so reset to high avoids a false edge
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign o_level = q.s2;
  assign o_rise = q.s2 & ~q.s3;
  assign o_fall = ~q.s2 & q.s3;
endmodule : scs_sync

// ### rtl/scs_host.sv
/*
  Host end: serial bus master taking single-byte write and read orders
  from an APB command register and reporting through a status register.
  Assumes the device end answers on the data line; no clock stretching.
*/
`timescale 1ns/1ps
`include "scs_regs.svh"
module scs_host #(
  parameter logic [7:0] QTR_CYC = `SCS_QTR_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  scs_link_if.host link,
  input wire logic i_ext_term_present,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr
);
  scs_pkg::scs_host_t q;
  scs_pkg::scs_host_t d;
  logic sda;
  logic ext_term;
  logic tick;
  logic [7:0] cw;

  // Byte sent in frame f: address write, register, then data or address read
  function automatic logic [7:0] tx_byte(input logic [1:0] f, input logic rd,
                                         input logic asel, input logic [7:0] rad,
                                         input logic [7:0] wdat);
    case (f)
      2'h0: tx_byte = {`SCS_DEV_ADDR_HI, asel, 1'b0};
      2'h1: tx_byte = rad;
      default: tx_byte = rd ? {`SCS_DEV_ADDR_HI, asel, 1'b1} : wdat;
    endcase
  endfunction : tx_byte

  scs_sync u_sda (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_async(link.sda),
                  .o_level(sda), .o_rise(), .o_fall());
  scs_sync u_ext (.i_sys_clk(i_sys_clk), .i_resetn(i_resetn),
                  .i_async(i_ext_term_present), .o_level(ext_term), .o_rise(), .o_fall());

  always_comb begin
    d = q;
    tick = (q.div == 8'h0);
    d.div = tick ? QTR_CYC - 8'h1 : q.div - 8'h1;
    cw = i_pwdata[23:16];
    // ---------------------------------------------------------------
    // APB slave, zero wait states
    // ---------------------------------------------------------------
    d.pready = i_psel & ~i_penable;
    d.pslverr = 1'b0;
    if (i_psel && !i_penable) begin
      d.prdata = 32'h0;
      if (i_paddr == `SCS_A_STAT) begin
        d.prdata = {16'h0, q.rdat, 5'h0, q.refused, q.nack, q.st != scs_pkg::SH_IDLE};
      end else if (i_paddr != `SCS_A_CMD) begin
        d.pslverr = 1'b1;
      end
    end
    if (i_psel && i_penable && q.pready && i_pwrite && i_paddr == `SCS_A_CMD &&
        i_pwdata[`SCS_C_GO] && q.st == scs_pkg::SH_IDLE) begin
      if (i_pwdata[15:8] == `SCS_REG_TX && !cw[`SCS_B_PTO]) begin
        cw[`SCS_B_OCL] = 1'b0;
      end
      // Outputs must not be left on with no termination anywhere
      if (!i_pwdata[`SCS_C_RD] && !ext_term &&
          ((i_pwdata[15:8] == `SCS_REG_HS && cw[`SCS_B_EN] && !q.pto) ||
           (i_pwdata[15:8] == `SCS_REG_TX && !cw[`SCS_B_PTO]))) begin
        d.refused = 1'b1;
      end else begin
        d.refused = 1'b0;
        d.nack = 1'b0;
        d.rd = i_pwdata[`SCS_C_RD];
        d.asel = i_pwdata[`SCS_C_ASEL];
        d.rad = i_pwdata[15:8];
        d.wdat = cw;
        d.fr = 2'h0;
        d.ph = 2'h0;
        d.div = QTR_CYC - 8'h1;
        d.st = scs_pkg::SH_STA;
        if (!i_pwdata[`SCS_C_RD] && i_pwdata[15:8] == `SCS_REG_TX) begin
          d.pto = cw[`SCS_B_PTO];
        end
      end
    end
    // ---------------------------------------------------------------
    // Bit engine, four quarter phases per bit
    // ---------------------------------------------------------------
    if (tick && q.st != scs_pkg::SH_IDLE) begin
      d.ph = q.ph + 2'h1;
      case (q.st)
        scs_pkg::SH_STA: begin
          case (q.ph)
            2'h0: d.sda_oe = 1'b0;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b1;
            default: begin
              d.scl_oe = 1'b1;
              d.bits = 4'h0;
              d.sh = tx_byte(q.fr, q.rd, q.asel, q.rad, q.wdat);
              d.st = scs_pkg::SH_BIT;
            end
          endcase
        end
        scs_pkg::SH_BIT: begin
          case (q.ph)
            2'h0: begin
              if (q.bits != 4'h8) begin
                d.sda_oe = (q.fr == 2'h3) ? 1'b0 : ~q.sh[7];
              end else begin
                d.sda_oe = (q.fr == 2'h3);
              end
            end
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bits != 4'h8) begin
                d.sh = {q.sh[6:0], sda};
              end else if (q.fr != 2'h3 && sda) begin
                d.nack = 1'b1;
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              d.bits = q.bits + 4'h1;
              if (q.bits == 4'h8) begin
                d.bits = 4'h0;
                if (q.nack) begin
                  d.st = scs_pkg::SH_STO;
                end else if (q.fr == 2'h3) begin
                  d.rdat = q.sh;
                  d.st = scs_pkg::SH_STO;
                end else if (q.fr == 2'h1 && q.rd) begin
                  d.fr = 2'h2;
                  d.st = scs_pkg::SH_STA;
                end else if (q.fr == 2'h2 && !q.rd) begin
                  d.st = scs_pkg::SH_STO;
                end else begin
                  d.fr = q.fr + 2'h1;
                  d.sh = tx_byte(q.fr + 2'h1, q.rd, q.asel, q.rad, q.wdat);
                end
              end
            end
          endcase
        end
        scs_pkg::SH_STO: begin
          case (q.ph)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            default: d.st = scs_pkg::SH_IDLE;
          endcase
        end
        default: d.st = scs_pkg::SH_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      q <= '{st: scs_pkg::SH_IDLE, div: 8'h0, ph: 2'h0, bits: 4'h0, fr: 2'h0,
             sh: 8'h00, scl_oe: 1'b0, sda_oe: 1'b0, rd: 1'b0, asel: 1'b0,
             rad: 8'h00, wdat: 8'h00, rdat: 8'h00, nack: 1'b0, refused: 1'b0,
             pto: 1'b1, prdata: 32'h0, pready: 1'b0, pslverr: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe = q.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = q.sda_oe;
  assign o_prdata = q.prdata;
  assign o_pready = q.pready;
  assign o_pslverr = q.pslverr;
endmodule : scs_host

// ### verif/scs_link_checker.sv
/*
  Link checker: timing and ownership assertions on the two-wire link.
  Assumes the host end runs with a quarter bit of 8 clock cycles.
*/
`timescale 1ns/1ps
module scs_link_checker (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_host_sda_oe,
  input wire logic i_dev_sda_oe,
  input wire logic i_scl,
  input wire logic i_sda
);
  // ---------------------------------------------------------------
  // Link properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  property p_dev_low;
    $changed(i_dev_sda_oe) |-> !i_scl;
  endproperty
  a_dev_low: assert property (p_dev_low)
    else $error("device moved data line while clock high");

  property p_dev_prompt;
    $rose(i_dev_sda_oe) |-> $past(i_scl, 8);
  endproperty
  a_dev_prompt: assert property (p_dev_prompt)
    else $error("device answer late after clock fall");

  // Both pulling low at clock low during the ack hand-over is harmless
  property p_no_fight;
    i_dev_sda_oe && i_scl |-> !i_host_sda_oe;
  endproperty
  a_no_fight: assert property (p_no_fight)
    else $error("both ends drive data line while clock high");

  property p_low_min;
    $fell(i_scl) |-> !i_scl [*8];
  endproperty
  a_low_min: assert property (p_low_min)
    else $error("clock low phase too short");

  property p_high_min;
    $rose(i_scl) |-> i_scl [*8];
  endproperty
  a_high_min: assert property (p_high_min)
    else $error("clock high phase too short");

  property p_start_hold;
    i_scl && $fell(i_sda) |-> i_scl [*7] ##[1:4] !i_scl;
  endproperty
  a_start_hold: assert property (p_start_hold)
    else $error("start condition not followed by clock fall");

  property p_stop_free;
    i_scl && $rose(i_sda) |-> !i_dev_sda_oe && !i_host_sda_oe ##1 i_scl [*8];
  endproperty
  a_stop_free: assert property (p_stop_free)
    else $error("bus not free after stop");

  property p_setup_after_fall;
    $fell(i_scl) |-> $stable(i_host_sda_oe) [*7];
  endproperty
  a_setup_after_fall: assert property (p_setup_after_fall)
    else $error("host data changed too soon after clock fall");
endmodule : scs_link_checker

// ### verif/tb_switch_config_serial_slave.sv
/*
  Testbench: APB orders into the host end, device outputs and link
  wires compared with a register model. Assumes rtl files compile first.
*/
`timescale 1ns/1ps
`include "scs_regs.svh"
`define CHK(a, b) begin \
  check_count++; \
  if ((a) !== (b)) begin \
    n_mismatch++; \
    $display("ERROR %0t: got %h want %h", $time, (a), (b)); \
  end \
end
module tb_switch_config_serial_slave;
  // ---------------------------------------------------------------
  // Bench state and instances
  // ---------------------------------------------------------------
  localparam logic [7:0] RA [6] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h13, 8'h20};
  localparam logic [7:0] DFLT [6] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00, 8'h03};
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic addr_sel = 1'b0;
  logic ext_term = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, st, rnd;
  logic pready, pslverr, err, f_en, f_sel, s_en, s_sel, oterm, ocl;
  logic [7:0] term, eq, ab;
  logic [1:0] boost;
  logic [7:0] wr_m [6];
  integer seed = 32'hdbbf577e;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  int nb = 8;
  int k, idx;

  scs_link_if link();
  scs_dev #(.UPD_CYC({6{16'h0578}}), .PULSE_CYC(200)) scs_dev_inst (
    .i_sys_clk(clk),
    .i_resetn(resetn),
    .link(link.dev),
    .i_addr_sel(addr_sel),
    .o_fast_switch_enable(f_en),
    .o_fast_source_select(f_sel),
    .o_side_switch_enable(s_en),
    .o_side_source_select(s_sel),
    .o_in_termination_on(term),
    .o_in_eq_high(eq),
    .o_out_boost_level(boost),
    .o_out_termination_on(oterm),
    .o_out_current_level_sel(ocl)
  );
  scs_host #(.QTR_CYC(8'h08)) scs_host_inst (
    .i_sys_clk(clk),
    .i_resetn(resetn),
    .link(link.host),
    .i_ext_term_present(ext_term),
    .i_psel(psel),
    .i_penable(penable),
    .i_pwrite(pwrite),
    .i_paddr(paddr),
    .i_pwdata(pwdata),
    .o_prdata(prdata),
    .o_pready(pready),
    .o_pslverr(pslverr)
  );
  scs_link_checker scs_link_checker_inst (
    .i_sys_clk(clk),
    .i_resetn(resetn),
    .i_host_sda_oe(link.host_sda_oe),
    .i_dev_sda_oe(link.dev_sda_oe),
    .i_scl(link.scl),
    .i_sda(link.sda)
  );

  initial begin
    forever #20 clk = ~clk;
  end

  // Last address byte after any start or repeated start
  always @(negedge link.sda) begin
    if (link.scl === 1'b1) nb = 0;
  end
  always @(posedge link.scl) begin
    if (nb < 8) ab = {ab[6:0], link.sda};
    nb++;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 95000) begin
      n_mismatch++;
      $display("ERROR %0t: run timed out", $time);
      close_out();
    end
  end

  // ---------------------------------------------------------------
  // Expectations and tasks
  // ---------------------------------------------------------------
  function automatic logic [7:0] sent(input int i, input logic [7:0] d);
    sent = (i == 5 && !d[1]) ? {d[7:1], 1'b0} : d;
  endfunction : sent

  function automatic logic [7:0] addr_byte(input logic s, input logic r);
    addr_byte = {6'h24, s, r};
  endfunction : addr_byte

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Request stands until the edge that samples ready high
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic r, input logic s, input int i, input logic [7:0] d);
    apb(1'b1, `SCS_A_CMD, {8'h00, d, RA[i], 5'h00, s, r, 1'b1});
    st = 32'h1;
    while (st[0] !== 1'b0) begin
      apb(1'b0, `SCS_A_STAT, 32'h0);
      st = rd;
    end
  endtask : cmd

  task automatic wr(input int i, input logic [7:0] d);
    cmd(1'b0, addr_sel, i, d);
    wr_m[i] = sent(i, d);
    `CHK(st[2:1], 2'b00);
    `CHK(ab, addr_byte(addr_sel, 1'b0));
  endtask : wr

  task automatic rdchk(input int i);
    cmd(1'b1, addr_sel, i, 8'h00);
    `CHK(st[15:8], wr_m[i]);
    `CHK(ab, addr_byte(addr_sel, 1'b1));
  endtask : rdchk

  // Outlasts the 1400-cycle window plus the termination drop
  task automatic settle();
    repeat (1700) @(posedge clk);
  endtask : settle

  task automatic chk_outs();
    `CHK(f_en, wr_m[0][6]);
    `CHK(f_sel, wr_m[0][0]);
    `CHK({s_en, s_sel}, {wr_m[1][6], wr_m[1][0]});
    `CHK(term, {8{wr_m[2][0]}});
    `CHK(eq, wr_m[4]);
    `CHK({boost, oterm, ocl}, wr_m[5][3:0]);
  endtask : chk_outs

  task automatic do_reset();
    resetn <= 1'b0;
    wr_m = DFLT;
    repeat (6) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  task automatic done(input string s);
    $display("test %s done, checks %0d", s, check_count);
  endtask : done

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    rnd = $random(seed);
    addr_sel <= rnd[0];
    do_reset();
    chk_outs();
    for (k = 0; k < 6; k++) begin
      rdchk(k);
    end
    apb(1'b0, 8'h08, 32'h0);
    `CHK({err, rd}, 33'h100000000);
    done("defaults");
    for (k = 0; k < 6; k++) begin
      rnd = $random(seed);
      idx = int'(rnd[15:8]) % 6;
      wr(idx, rnd[7:0]);
      settle();
      rdchk(idx);
      chk_outs();
    end
    done("random_writes");
    for (k = 0; k < 4; k++) begin
      wr(5, {4'h0, k[1:0], 2'h3});
      settle();
      chk_outs();
    end
    done("boost_levels");
    ext_term <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(1'b0, addr_sel, 5, 8'h01);
    `CHK(st[2], 1'b1);
    ext_term <= 1'b1;
    repeat (4) @(posedge clk);
    wr(5, 8'h01);
    rdchk(5);
    ext_term <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(1'b0, addr_sel, 0, 8'h40);
    `CHK(st[2], 1'b1);
    ext_term <= 1'b1;
    done("refusals");
    cmd(1'b0, ~addr_sel, 0, 8'h00);
    `CHK(st[1], 1'b1);
    `CHK(ab, addr_byte(~addr_sel, 1'b0));
    rdchk(0);
    done("address_mismatch");
    do_reset();
    chk_outs();
    wr(0, 8'h41);
    `CHK(f_sel, 1'b0);
    settle();
    `CHK(f_sel, 1'b1);
    wr(3, 8'ha5);
    settle();
    wr(0, 8'h40);
    `CHK({f_sel, term}, 9'h05a);
    wr(0, 8'h41);
    `CHK(f_sel, 1'b0);
    settle();
    chk_outs();
    done("update_window");
    close_out();
  end
endmodule : tb_switch_config_serial_slave
